// ==== inc/uem_consts.svh ====
`ifndef UEM_CONSTS_SVH
`define UEM_CONSTS_SVH

// register byte addresses
`define UEM_OFF_MASK 12'h108
`define UEM_OFF_STATUS 12'h104
`define UEM_OFF_LOG 12'h11C
// first error pointer register (control), pointer in bits 4:0
`define UEM_OFF_CTRL 12'h118
`define UEM_OFF_REPORT 12'h140
// writable mask bits: 0, 4, 5, 12, 13, 16..21
`define UEM_MASK_WMASK 32'h003F3031
`define UEM_MASK_RESET 32'h00000000
`define UEM_STATUS_WMASK 32'h003F3031
`define UEM_BIT_CPL_TIMEOUT 14
`define UEM_BIT_CPL_ABORT 15
`define UEM_PTR_W 5
`define UEM_ADDR_W 12

`endif

// ==== inc/uem_pkg.sv ====
package uem_pkg;

  typedef struct packed {
    logic        valid;
    logic [4:0]  idx;
    logic        fatal;
  } uem_report_t;

  typedef struct packed {
    logic [31:0] mask;
    logic [31:0] status;
    logic [4:0]  first_ptr;
    logic        ptr_valid;
    logic [31:0] log_hdr;
    logic        log_valid;
    logic [31:0] prdata;
    uem_report_t report;
  } uem_state_t;

endpackage

// ==== hdl/uem_event_pick.sv ====
`include "uem_consts.svh"

// picks the lowest-numbered event of a vector; one-shot priority encoder
module uem_event_pick (
  input wire logic [31:0] events, // candidate events
  output logic any, // some event present
  output logic [4:0] idx // lowest set position
);
  always_comb begin
    any = 1'b0;
    idx = 5'h00;
    for (int i = 31; i >= 0; i--) begin
      if (events[i]) begin
        any = 1'b1;
        idx = 5'(i);
      end
    end
  end
endmodule

// ==== hdl/uem_apb_decode.sv ====
`include "uem_consts.svh"

// apb slave front: zero wait states, error on unmapped address
module uem_apb_decode (
  input wire logic psel, // select
  input wire logic penable, // access phase
  input wire logic pwrite, // direction
  input wire logic [11:0] paddr, // byte address
  output logic pready, // always ready
  output logic pslverr, // unmapped access
  output logic wr_mask, // mask write strobe
  output logic wr_status, // status w1c strobe
  output logic hit_any // address mapped
);
  logic acc;
  assign acc = psel & penable;
  assign hit_any = (paddr == `UEM_OFF_MASK) || (paddr == `UEM_OFF_STATUS) ||
                   (paddr == `UEM_OFF_CTRL) || (paddr == `UEM_OFF_LOG) ||
                   (paddr == `UEM_OFF_REPORT);
  assign pready = 1'b1;
  assign pslverr = acc & ~hit_any;
  assign wr_mask = acc & pwrite & (paddr == `UEM_OFF_MASK);
  assign wr_status = acc & pwrite & (paddr == `UEM_OFF_STATUS);
endmodule

// ==== hdl/uem_mask_reg.sv ====
// Design decision made here: the APB slave port.
`include "uem_consts.svh"

module uem_mask_reg (
  input wire logic pclk, // core clock
  input wire logic presetn, // fundamental reset, async low
  input wire logic psel, // apb select
  input wire logic penable, // apb enable
  input wire logic pwrite, // apb direction
  input wire logic [11:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error
  input wire logic [31:0] err_event, // one-cycle error detections
  input wire logic [31:0] err_hdr, // header of current event
  input wire logic [31:0] severity, // per-bit fatal select
  output uem_pkg::uem_report_t report, // message toward root complex
  output logic [31:0] mask_out // current mask value
);
  uem_pkg::uem_state_t s_r, s_nxt;
  logic wr_mask, wr_status, hit_any;
  logic unm_any;
  logic [4:0] unm_idx;
  logic [31:0] unmasked, legal_ev;

  uem_apb_decode u_dec (
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pready(pready),
    .pslverr(pslverr),
    .wr_mask(wr_mask),
    .wr_status(wr_status),
    .hit_any(hit_any)
  );

  // only implemented event positions count; hardwired ones never fire
  assign legal_ev = err_event & `UEM_STATUS_WMASK;
  // masked events drop out here
  assign unmasked = legal_ev & ~s_r.mask;

  uem_event_pick u_pick (
    .events(unmasked),
    .any(unm_any),
    .idx(unm_idx)
  );

  function automatic logic [31:0] read_mux(input uem_pkg::uem_state_t st,
                                           input logic [11:0] a);
    logic [31:0] d;
    d = 32'h00000000;
    unique case (a)
      `UEM_OFF_MASK: d = st.mask;
      `UEM_OFF_STATUS: d = st.status;
      `UEM_OFF_CTRL: d = {27'h0000000, st.first_ptr};
      `UEM_OFF_LOG: d = st.log_hdr;
      `UEM_OFF_REPORT: d = {25'h0000000, st.report.valid, st.report.idx, st.report.fatal};
      default: d = 32'h00000000;
    endcase
    return d;
  endfunction

  always_comb begin
    s_nxt = s_r;
    s_nxt.report = '0;
    if (wr_mask) begin
      s_nxt.mask = pwdata & `UEM_MASK_WMASK;
    end
    if (wr_status) begin
      s_nxt.status = s_r.status & ~(pwdata & `UEM_STATUS_WMASK);
      // clearing the pointed-at status rearms pointer and log together
      if (pwdata[s_r.first_ptr]) begin
        s_nxt.ptr_valid = 1'b0;
        s_nxt.log_valid = 1'b0;
      end
    end
    s_nxt.status = s_nxt.status | legal_ev;
    if (unm_any && !s_nxt.ptr_valid) begin
      s_nxt.first_ptr = unm_idx;
      s_nxt.ptr_valid = 1'b1;
    end
    // log only unmasked
    // an event in the clearing cycle wins, so its header is not lost
    if (unm_any && !s_nxt.log_valid) begin
      s_nxt.log_hdr = err_hdr;
      s_nxt.log_valid = 1'b1;
    end
    if (unm_any) begin
      s_nxt.report.valid = 1'b1;
      s_nxt.report.idx = unm_idx;
      s_nxt.report.fatal = severity[unm_idx];
    end
    s_nxt.prdata = (psel && !penable && !pwrite && hit_any) ? read_mux(s_r, paddr) : 32'h00000000;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r <= '0;
      s_r.mask <= `UEM_MASK_RESET;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign prdata = s_r.prdata;
  assign report = s_r.report;
  assign mask_out = s_r.mask;
endmodule

// ==== sim/uem_rc_model.sv ====
module uem_rc_model (
  input wire logic pclk, // clk
  input wire uem_pkg::uem_report_t report, // error message
  output int n_msgs // messages taken
);
  timeunit 1ns;
  timeprecision 100ps;
  int cnt_r = 0;
  assign n_msgs = cnt_r;
  // takes every message at once: a root port never stalls them
  always @(posedge pclk)
    if (report.valid) cnt_r <= cnt_r + 1;
endmodule

// ==== sim/uem_mask_reg_monitor.sv ====
`include "uem_consts.svh"
module uem_mon (
  input wire logic pclk, // clk
  input wire logic presetn, // rst
  input wire logic psel, // sel
  input wire logic penable, // en
  input wire logic pwrite, // dir
  input wire logic [11:0] paddr, // addr
  input wire logic [31:0] pwdata, // wdata
  input wire logic [31:0] prdata, // rdata
  input wire logic [31:0] err_event, // events
  input wire uem_pkg::uem_report_t report, // msg
  input wire logic [31:0] mask_out // mask
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [31:0] live_r;
  wire logic mwr = psel & penable & pwrite & (paddr == `UEM_OFF_MASK);
  wire logic [31:0] live_nxt = err_event & ~mask_out & `UEM_MASK_WMASK;
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn) live_r <= '0;
    else live_r <= live_nxt;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_wr; mwr |=> mask_out == ($past(pwdata) & `UEM_MASK_WMASK); endproperty
  a_wr: assert property (p_wr) else $error("bad mask write");
  property p_ro; mask_out[15:14] == 2'h0; endproperty
  a_ro: assert property (p_ro) else $error("bits 14 15 set");
  property p_rsv; (mask_out & ~`UEM_MASK_WMASK) == 32'h0; endproperty
  a_rsv: assert property (p_rsv) else $error("reserved set");
  property p_hold; !mwr |=> $stable(mask_out); endproperty
  a_hold: assert property (p_hold) else $error("mask drift");
  property p_rd; psel && penable && !pwrite && paddr == `UEM_OFF_MASK |-> prdata == mask_out;
  endproperty
  a_rd: assert property (p_rd) else $error("bad readback");
  property p_nrep; report.valid |-> live_r[report.idx]; endproperty
  a_nrep: assert property (p_nrep) else $error("masked report");
  property p_rep; |live_nxt |=> report.valid; endproperty
  a_rep: assert property (p_rep) else $error("lost report");
  property p_idx; report.valid |-> (live_r & ((32'h1 << report.idx) - 32'h1)) == 32'h0;
  endproperty
  a_idx: assert property (p_idx) else $error("wrong index");
endmodule
bind uem_mask_reg uem_mon u_uem_mon (.*);

// ==== sim/uem_mask_reg_bench.sv ====
`include "uem_consts.svh"
module aer_uncorrectable_error_mask_bench;
  timeunit 1ns;
  timeprecision 100ps;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, err_event = '0, err_hdr = '0, severity = '0, prdata, mask_out, rd, m;
  logic [31:0] wm = `UEM_MASK_WMASK;
  logic [31:0] h, e, st, exp_log = '0;
  logic [4:0] exp_ptr = '0;
  logic rd_err;
  uem_pkg::uem_report_t report;
  int n_fail = 0, samples_checked = 0, n_msgs, exp_msgs = 0, seed = 32'hf6be;
  always #2 pclk = ~pclk;
  uem_mask_reg u_uem_mask_reg (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .err_event(err_event), .err_hdr(err_hdr), .severity(severity),
    .report(report), .mask_out(mask_out));
  uem_rc_model u_uem_rc_model (.pclk(pclk), .report(report), .n_msgs(n_msgs));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: %h not %h", $time, got, exp);
    end
  endtask
  task automatic print_verdict;
    $display("checks %0d fails %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    for (k = 0; k < 9 && !(psel && penable && pready); k++) @(posedge pclk);
    rd = prdata;
    rd_err = pslverr;
    psel <= 0;
    penable <= 0;
    if (k == 9) begin
      n_fail++;
      print_verdict;
    end
  endtask
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1;
    severity <= $random(seed);
    apb(0, `UEM_OFF_MASK, 0);
    chk(rd, 32'h0);
    chk(rd_err, 1'b0);
    apb(0, 12'hFF0, 0);
    chk(rd, 32'h0);
    chk(rd_err, 1'b1);
    for (int i = 0; i < 5; i++) begin
      m = i ? $random(seed) : 32'hFFFFFFFF;
      apb(1, `UEM_OFF_MASK, m);
      apb(0, `UEM_OFF_MASK, 0);
      chk(rd, m & wm);
      chk(mask_out, m & wm);
      for (int b = 0; b < 22; b++) if (wm[b]) begin
        exp_msgs += !m[b];
        @(posedge pclk) err_event <= 32'h1 << b;
        h = $random(seed);
        err_hdr <= h;
        e = m[b] ? 32'h0 : {25'h0, 1'b1, 5'(b), severity[b]};
        if (!m[b]) begin
          exp_ptr = 5'(b);
          exp_log = h;
        end
        @(posedge pclk) err_event <= 32'h0;
        #1 chk(report.valid, !m[b]);
        chk(report, e);
        apb(0, `UEM_OFF_STATUS, 0);
        chk(rd[b], 1'b1);
        st = rd;
        apb(0, `UEM_OFF_CTRL, 0);
        chk(rd, {27'h0, exp_ptr});
        apb(0, `UEM_OFF_LOG, 0);
        chk(rd, exp_log);
        apb(1, `UEM_OFF_STATUS, st);
      end
      $display("mask pass %0d done", i);
    end
    chk(n_msgs, exp_msgs);
    print_verdict;
  end
endmodule
